// ===== sim/tsp_framer_model.sv
// Behavioural framer that feeds the parallel and serial transmit inputs.
`timescale 1ns/100ps
module tsp_framer_model (
  input wire logic run,
  input wire logic master,
  input wire logic inv,
  input wire logic stuck,
  input wire logic master_clk,
  input wire logic [7:0] word,
  output logic par_clk,
  output logic [3:0] nibble,
  output logic ser_clk,
  output logic ser_data
);
  int pi = 0;
  int si = 0;

  // Start from known pin levels before any clock process runs.
  initial begin
    par_clk = 1'b0;
    nibble = 4'h5;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end

  // Alternates the two halves of the pattern word, high half first.
  task next_nib();
    nibble = pi[0] ? word[3:0] : word[7:4];
    pi++;
  endtask

  // Host clock of 125 ns; between frames it stands still and the nibble
  // pins keep changing so that stale data can never pass for valid data.
  always begin
    if (run && !master) begin
      #62.5;
      par_clk = ~par_clk;
      if (par_clk == inv)
        next_nib();
    end else begin
      #4;
      par_clk = 1'b0;
      if (!run)
        nibble = ~nibble;
    end
  end

  // In master mode nibbles launch on the edge away from the capture edge.
  always @(master_clk) begin
    if (run && master && master_clk == inv)
      next_nib();
  end

  // Serial clock at the line bit rate; stuck models a dead serial input.
  always begin
    #16;
    if (run) begin
      ser_clk = ~ser_clk;
      if (ser_clk == inv) begin
        ser_data = stuck ? 1'b0 : word[7 - si];
        si = (si + 1) % 8;
      end
    end else begin
      ser_clk = 1'b0;
      ser_data = ~ser_data;
    end
  end
endmodule

// ===== sim/tsp_tx_port_tb.sv
// Self-checking bench of the transmit system port and status block.
`timescale 1ns/100ps
module tsp_tx_port_tb;
  localparam int QDIV = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic los = 1'b0;
  logic lol = 1'b0;
  logic run = 1'b0;
  logic master = 1'b0;
  logic inv = 1'b0;
  logic stuck = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] pattern = 8'h8e;
  logic [7:0] rdata, w, a;
  logic [3:0] nib;
  logic pclk_in, pclk_out, pclk_oe, sdat, sclk, coax, coax_oe, lclk, nrz, irq;
  logic [31:0] seed = 32'h4d19;
  logic [31:0] r;
  int mismatches = 0;
  int tests_run = 0;
  int n, m;

  always #2 clk = ~clk;

  // The idle limit must exceed the longest run of equal bits in the pattern
  // (three bits, 24 cycles), or a live stream would look like a dead input.
  tsp_tx_port #(.QUARTER_DIV(QDIV), .TX_INPUT_UNLOCKED_FLAG_CYCLES(32)) u_dut (
    .CLK(clk),
    .RESET_N(rst_n),
    .CE(ce),
    .REG_ADDR(addr),
    .REG_WDATA(wdata),
    .REG_WR(wr),
    .REG_RD(rd),
    .REG_RDATA(rdata),
    .RX_SIGNAL_LOST_IN(los),
    .RX_CLOCK_UNLOCKED_IN(lol),
    .PAR_TX_NIBBLE(nib),
    .PAR_TX_CLOCK_IN(pclk_in),
    .PAR_TX_CLOCK_OUT(pclk_out),
    .PAR_TX_CLOCK_OE(pclk_oe),
    .SER_TX_DATA_IN(sdat),
    .SER_TX_CLOCK_IN(sclk),
    .COAX_LINE_OUT(coax),
    .COAX_LINE_OE(coax_oe),
    .LINE_TX_CLOCK_OUT(lclk),
    .OPTICAL_NRZ_OUT(nrz),
    .IRQ(irq)
  );

  tsp_framer_model u_host (
    .run(run),
    .master(master),
    .inv(inv),
    .stuck(stuck),
    .master_clk(pclk_out),
    .word(pattern),
    .par_clk(pclk_in),
    .nibble(nib),
    .ser_clk(sclk),
    .ser_data(sdat)
  );

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // True when v is some rotation of the pattern sent high bit first.
  function automatic logic rot_ok(logic [7:0] v);
    rot_ok = 1'b0;
    for (int i = 0; i < 8; i++)
      if (v == ((pattern << i) | (pattern >> (8 - i))))
        rot_ok = 1'b1;
  endfunction

  function automatic logic pick(int which);
    case (which)
      0: pick = lclk;
      1: pick = pclk_out;
      default: pick = coax;
    endcase
  endfunction

  task chk(string name, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  // Waits k edges, then 1 ns so registered outputs have settled.
  task cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task wreg(logic [7:0] ad, logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge.
  task rchk(logic [7:0] ad, logic [7:0] e);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("register %h", ad), rdata, e);
  endtask

  // Cycles between two changes of an output, after aligning to a change.
  task hp(input int which, output int cnt);
    logic p;
    for (int j = 0; j < 2; j++) begin
      p = pick(which);
      cnt = 0;
      while (pick(which) === p && cnt < 99) begin
        cyc(1);
        cnt++;
      end
    end
  endtask

  // Eight line bits sampled mid-bit; a wrong bit length breaks the match.
  task grab(output logic [7:0] v);
    logic p;
    p = nrz;
    for (int i = 0; i < 300 && nrz === p; i++)
      cyc(1);
    cyc(2 * QDIV);
    for (int i = 0; i < 8; i++) begin
      v = {v[6:0], nrz};
      cyc(4 * QDIV);
    end
  endtask

  task results();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang ends the run well beyond the expected 80 us at worst.
  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(tsp_pkg::REG_MODE, tsp_pkg::MODE_RST);
    rchk(tsp_pkg::REG_SIGCTL, tsp_pkg::SIGCTL_RST);
    rchk(tsp_pkg::REG_MODE2, tsp_pkg::MODE2_RST);
    rchk(tsp_pkg::REG_IRQ_MASK, 8'h00);
    // Random writes to reserved and unmapped places must read back zero.
    for (int i = 0; i < 8; i++) begin
      r = xorshift();
      a = r[0] ? {7'h03, r[1]} : 8'h0a + {6'h00, r[3:2]};
      wreg(a, r[15:8]);
      rchk(a, tsp_pkg::TEST_RESERVED_A_VAL);
    end
    // A low clock enable must leave every register as it stands.
    ce <= 1'b0;
    wreg(tsp_pkg::REG_IRQ_MASK, 8'h1f);
    ce <= 1'b1;
    rchk(tsp_pkg::REG_IRQ_MASK, 8'h00);
    $display("Test registers done");
    wreg(tsp_pkg::REG_MODE2, 8'h00);
    run <= 1'b1;
    // Every transmit mode with both capture edges, fiber line.
    for (int k = 0; k < 10; k++) begin
      m = k % 5;
      inv <= (k >= 5);
      master <= (m == 0);
      wreg(tsp_pkg::REG_MODE, {5'h01, m[2:0]});
      wreg(tsp_pkg::REG_SIGCTL, {6'h00, k >= 5, 1'b1});
      cyc(100);
      wreg(tsp_pkg::REG_SIGCTL, {6'h00, k >= 5, 1'b0});
      cyc(200);
      chk("clock output enable", pclk_oe, m == 0);
      chk("coax enable", coax_oe, 8'h00);
      grab(w);
      chk("line bit order", rot_ok(w), 8'h01);
      if (m == 0) begin
        hp(1, n);
        chk("parallel clock half period", n[7:0], 8 * QDIV);
      end
      $display("Test mode %0d edge %0d done", m, k / 5);
    end
    hp(0, n);
    chk("line clock half period", n[7:0], QDIV);
    // Coax line: zeros are low then high within each bit.
    pattern <= 8'h00;
    wreg(tsp_pkg::REG_MODE2, 8'h80);
    cyc(300);
    chk("coax enable", coax_oe, 8'h01);
    chk("optical idle", nrz, 8'h00);
    hp(2, n);
    chk("coax zero half bit", n[7:0], 2 * QDIV);
    wreg(tsp_pkg::REG_MODE, 8'h04);
    cyc(3);
    chk("coax enable off", coax_oe, 8'h00);
    $display("Test line modes done");
    // Status bits, FIFO held centred so only the live conditions show.
    pattern <= 8'h8e;
    wreg(tsp_pkg::REG_MODE, 8'h0c);
    wreg(tsp_pkg::REG_SIGCTL, 8'h01);
    cyc(100);
    rchk(tsp_pkg::REG_STATUS, 8'h02);
    rchk(tsp_pkg::REG_STATUS, 8'h00);
    los <= 1'b1;
    lol <= 1'b1;
    cyc(8);
    rchk(tsp_pkg::REG_STATUS, 8'h10);
    los <= 1'b0;
    cyc(8);
    rchk(tsp_pkg::REG_STATUS, 8'h18);
    lol <= 1'b0;
    cyc(8);
    rchk(tsp_pkg::REG_STATUS, 8'h08);
    rchk(tsp_pkg::REG_STATUS, 8'h00);
    stuck <= 1'b1;
    cyc(60);
    rchk(tsp_pkg::REG_STATUS, 8'h02);
    stuck <= 1'b0;
    cyc(60);
    rchk(tsp_pkg::REG_STATUS, 8'h02);
    rchk(tsp_pkg::REG_STATUS, 8'h00);
    wreg(tsp_pkg::REG_MODE, 8'h0b);
    stuck <= 1'b1;
    cyc(60);
    rchk(tsp_pkg::REG_STATUS, 8'h00);
    stuck <= 1'b0;
    chk("masked interrupt", irq, 8'h00);
    $display("Test status done");
    // A 125 ns host clock outruns the line, so the FIFO must overflow.
    wreg(tsp_pkg::REG_MODE, 8'h09);
    cyc(100);
    wreg(tsp_pkg::REG_SIGCTL, 8'h00);
    wreg(tsp_pkg::REG_IRQ_STAT, 8'h1f);
    wreg(tsp_pkg::REG_IRQ_MASK, 8'h01);
    cyc(2);
    chk("interrupt clear", irq, 8'h00);
    for (n = 0; n < 12000 && irq !== 1'b1; n++)
      cyc(1);
    chk("fifo error interrupt", irq, 8'h01);
    rchk(tsp_pkg::REG_STATUS, 8'h01);
    wreg(tsp_pkg::REG_IRQ_MASK, 8'h00);
    cyc(2);
    chk("interrupt masked", irq, 8'h00);
    wreg(tsp_pkg::REG_IRQ_MASK, 8'h01);
    cyc(2);
    chk("interrupt unmasked", irq, 8'h01);
    wreg(tsp_pkg::REG_SIGCTL, 8'h01);
    cyc(4);
    rchk(tsp_pkg::REG_STATUS, 8'h00);
    wreg(tsp_pkg::REG_IRQ_STAT, 8'h01);
    cyc(2);
    chk("interrupt cleared", irq, 8'h00);
    rchk(tsp_pkg::REG_IRQ_STAT, 8'h00);
    $display("Test fifo error done");
    results();
  end
endmodule

// ===== verilog/tsp_nibble_fifo.sv
// Small transmit FIFO that absorbs phase drift between capture and line.
`timescale 1ns/100ps
module tsp_nibble_fifo #(
  parameter int W = 4,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic recentre,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic rd,
  output logic [W-1:0] rdata,
  output logic err
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [AW:0] cnt;
    logic err;
  } tsp_fifo_type;

  tsp_fifo_type q;
  tsp_fifo_type d;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO depth must be a power of two of at least two.");
    end
  endgenerate

  // A write into a full FIFO with no read in the same cycle, or a read from an empty one, is a phase error;
  // the offending access is dropped so pointers never cross.
  always_comb begin
    logic do_wr;
    logic do_rd;
    do_wr = 1'b0;
    do_rd = 1'b0;
    d = q;
    d.err = 1'b0;
    if (recentre) begin
      d.rp = '0;
      d.wp = AW'(DEPTH / 2);
      d.cnt = (AW + 1)'(DEPTH / 2);
    end else begin
      do_rd = rd && (q.cnt != '0);
      do_wr = wr && ((q.cnt != (AW + 1)'(DEPTH)) || do_rd);
      d.err = (rd && !do_rd) || (wr && !do_wr);
      if (do_wr) begin
        d.mem[q.wp] = wdata;
        d.wp = q.wp + AW'(1);
      end
      if (do_rd) begin
        d.rp = q.rp + AW'(1);
      end
      if (do_wr && !do_rd) begin
        d.cnt = q.cnt + (AW + 1)'(1);
      end else if (do_rd && !do_wr) begin
        d.cnt = q.cnt - (AW + 1)'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{mem: '0, rp: '0, wp: AW'(DEPTH / 2),
             cnt: (AW + 1)'(DEPTH / 2), err: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata = q.mem[q.rp];
  assign err = q.err;

endmodule

// ===== verilog/tsp_pin_sampler.sv
// Two-flop synchroniser with edge detection for asynchronous input pins.
`timescale 1ns/100ps
module tsp_pin_sampler #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tsp_sync_type;

  tsp_sync_type q;
  tsp_sync_type d;

  generate
    if (W < 1) begin : g_chk
      $error("Sampler width must be at least one.");
    end
  endgenerate

  // The first stage feeds only the second; edges come from stages two and three.
  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs are taken from the settled stages only.
  assign level = q.s2;
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;

endmodule

// ===== verilog/tsp_pkg.sv
// Shared constants, types and register map of the transmit port and status block.
package tsp_pkg;

  // Register bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_SIGCTL = 8'h01;
  localparam logic [7:0] REG_MODE2 = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_TEST_RESERVED_A_A = 8'h06;
  localparam logic [7:0] REG_TEST_RESERVED_A_B = 8'h07;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h09;

  // Field positions.
  localparam int ST_TX_FIFO_PHASE_ERROR = 0;
  localparam int ST_TX_INPUT_UNLOCKED_FLAG = 1;
  localparam int ST_RX_CLOCK_UNLOCKED_FLAG = 3;
  localparam int ST_RX_SIGNAL_LOST_FLAG = 4;
  localparam int EV_W = 5;
  localparam int SC_TX_FIFO_POINTER_RESET = 0;
  localparam int SC_TX_CLOCK_EDGE_INVERT = 1;
  localparam int MC_TXEN = 3;
  localparam int MC_MODE_W = 3;
  localparam int M2_CMI = 7;

  // Reset values.
  localparam logic [7:0] MODE_RST = 8'h08;
  localparam logic [7:0] SIGCTL_RST = 8'h00;
  localparam logic [7:0] MODE2_RST = 8'h80;
  localparam logic [7:0] TEST_RESERVED_A_VAL = 8'h00;

  // Transmit timing modes.
  typedef enum logic [2:0] {
    TSP_MASTER_PAR = 3'h0,
    TSP_SLAVE_PAR = 3'h1,
    TSP_LOOP_PAR = 3'h2,
    TSP_SER_EXT = 3'h3,
    TSP_SER_CDR = 3'h4
  } tsp_mode_type;

  // Timing: clock period, idle time that flags lost serial input.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TX_INPUT_UNLOCKED_FLAG_TIMEOUT_NS = 1000;
  localparam int TX_INPUT_UNLOCKED_FLAG_CYCLES = (TX_INPUT_UNLOCKED_FLAG_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int QUARTER_DIV = 2;
  localparam int NIBBLE_W = 4;
  localparam int FIFO_DEPTH = 4;

  // Pins that come from outside the clock domain, in sampler order.
  typedef struct packed {
    logic [3:0] nibble;
    logic par_clk;
    logic ser_data;
    logic ser_clk;
    logic rx_los;
    logic rx_ppm;
  } tsp_pins_type;

endpackage

// ===== verilog/tsp_tx_port.sv
// Transmit system port: capture, FIFO, serialiser, line coding and status.
`timescale 1ns/100ps
module tsp_tx_port #(
  parameter int QUARTER_DIV = tsp_pkg::QUARTER_DIV,
  parameter int FIFO_DEPTH = tsp_pkg::FIFO_DEPTH,
  parameter int TX_INPUT_UNLOCKED_FLAG_CYCLES = tsp_pkg::TX_INPUT_UNLOCKED_FLAG_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic RX_SIGNAL_LOST_IN,
  input wire logic RX_CLOCK_UNLOCKED_IN,
  input wire logic [3:0] PAR_TX_NIBBLE,
  input wire logic PAR_TX_CLOCK_IN,
  output logic PAR_TX_CLOCK_OUT,
  output logic PAR_TX_CLOCK_OE,
  input wire logic SER_TX_DATA_IN,
  input wire logic SER_TX_CLOCK_IN,
  output logic COAX_LINE_OUT,
  output logic COAX_LINE_OE,
  output logic LINE_TX_CLOCK_OUT,
  output logic OPTICAL_NRZ_OUT,
  output logic IRQ
);

  typedef struct packed {
    tsp_pkg::tsp_mode_type mode;
    logic tx_en;
    logic tx_clock_edge_invert;
    logic tx_fifo_pointer_reset;
    logic cmi;
    logic [tsp_pkg::EV_W-1:0] stat;
    logic [tsp_pkg::EV_W-1:0] irq_stat;
    logic [tsp_pkg::EV_W-1:0] irq_mask;
    logic [tsp_pkg::EV_W-1:0] prev;
    logic [7:0] rdata;
    logic [7:0] qcnt;
    logic [1:0] quarter;
    logic [1:0] bitcnt;
    logic [3:0] shreg;
    logic cur_bit;
    logic cmi_lvl;
    logic [3:0] ser_acc;
    logic [1:0] ser_cnt;
    logic [15:0] idle_cnt;
    logic ser_prev;
    logic line_clk;
    logic par_clk;
    logic par_oe;
    logic coax;
    logic coax_oe;
    logic nrz;
    logic irq;
  } tsp_state_type;

  tsp_state_type q;
  tsp_state_type d;
  tsp_pkg::tsp_pins_type raw;
  tsp_pkg::tsp_pins_type lvl;
  tsp_pkg::tsp_pins_type rise;
  tsp_pkg::tsp_pins_type fall;
  logic fifo_wr;
  logic fifo_rd;
  logic [3:0] fifo_wdata;
  logic [3:0] fifo_rdata;
  logic fifo_err;
  logic tx_input_unlocked_flag_cond;
  logic [tsp_pkg::EV_W-1:0] cond;

  generate
    if (QUARTER_DIV < 1 || QUARTER_DIV > 255 || TX_INPUT_UNLOCKED_FLAG_CYCLES < 1 ||
        TX_INPUT_UNLOCKED_FLAG_CYCLES > 65535) begin : g_chk
      $error("Line divider or idle limit out of range.");
    end
  endgenerate

  // True for all three parallel modes, master included.
  function automatic logic is_parallel(tsp_pkg::tsp_mode_type m);
    return (m == tsp_pkg::TSP_MASTER_PAR) || (m == tsp_pkg::TSP_SLAVE_PAR) ||
           (m == tsp_pkg::TSP_LOOP_PAR);
  endfunction

  // Read value for one register offset; unmapped offsets read zero.
  function automatic logic [7:0] read_value(logic [7:0] a, tsp_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      tsp_pkg::REG_MODE: v = {4'h0, s.tx_en, s.mode};
      tsp_pkg::REG_SIGCTL: v = {6'h00, s.tx_clock_edge_invert, s.tx_fifo_pointer_reset};
      tsp_pkg::REG_MODE2: v = {s.cmi, 7'h00};
      tsp_pkg::REG_STATUS: v = {3'h0, s.stat};
      tsp_pkg::REG_TEST_RESERVED_A_A: v = tsp_pkg::TEST_RESERVED_A_VAL;
      tsp_pkg::REG_TEST_RESERVED_A_B: v = tsp_pkg::TEST_RESERVED_A_VAL;
      tsp_pkg::REG_IRQ_STAT: v = {3'h0, s.irq_stat};
      tsp_pkg::REG_IRQ_MASK: v = {3'h0, s.irq_mask};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // In master mode our own divided clock goes through the same sampler as
  // the data, so the capture edge lines up with the synchronised nibble.
  assign raw = '{nibble: PAR_TX_NIBBLE,
                 par_clk: (q.mode == tsp_pkg::TSP_MASTER_PAR) ?
                          q.par_clk : PAR_TX_CLOCK_IN,
                 ser_data: SER_TX_DATA_IN, ser_clk: SER_TX_CLOCK_IN,
                 rx_los: RX_SIGNAL_LOST_IN, rx_ppm: RX_CLOCK_UNLOCKED_IN};

  tsp_pin_sampler #(
    .W($bits(tsp_pkg::tsp_pins_type))
  ) u_sampler (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .pin(raw),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  tsp_nibble_fifo #(
    .W(tsp_pkg::NIBBLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .recentre(q.tx_fifo_pointer_reset),
    .wr(fifo_wr),
    .wdata(fifo_wdata),
    .rd(fifo_rd),
    .rdata(fifo_rdata),
    .err(fifo_err)
  );

  // Next-state logic for capture, line timing, coding and registers.
  always_comb begin
    logic cap;
    logic wrap;
    logic bit_start;
    logic mid_bit;
    logic serial_cap;
    logic rd_stat;
    cap = q.tx_clock_edge_invert ? fall.ser_clk : rise.ser_clk;
    d = q;
    fifo_wr = 1'b0;
    fifo_rd = 1'b0;
    fifo_wdata = lvl.nibble;
    wrap = (q.qcnt == 8'(QUARTER_DIV - 1));
    bit_start = wrap && (q.quarter == 2'h3);
    mid_bit = wrap && (q.quarter == 2'h1);
    // Capture edge follows the inversion control; parallel uses its clock.
    if (is_parallel(q.mode)) begin
      cap = q.tx_clock_edge_invert ? fall.par_clk : rise.par_clk;
    end
    // Whole nibbles go straight in; serial bits gather MSB first.
    serial_cap = (q.mode == tsp_pkg::TSP_SER_CDR) ? mid_bit :
                 ((q.mode == tsp_pkg::TSP_SER_EXT) && cap);
    if (is_parallel(q.mode)) begin
      fifo_wr = cap;
    end else if (serial_cap) begin
      d.ser_acc = {q.ser_acc[2:0], lvl.ser_data};
      d.ser_cnt = q.ser_cnt + 2'h1;
      fifo_wr = (q.ser_cnt == 2'h3);
      fifo_wdata = d.ser_acc;
    end
    // Quarter-bit counter; the line clock toggles every quarter bit.
    d.qcnt = wrap ? 8'h00 : q.qcnt + 8'h01;
    if (wrap) begin
      d.quarter = q.quarter + 2'h1;
      d.line_clk = ~q.line_clk;
    end
    // Four line bits per nibble, the first one being bit 3.
    if (bit_start) begin
      d.bitcnt = q.bitcnt + 2'h1;
      if (q.bitcnt == 2'h3) begin
        fifo_rd = 1'b1;
        d.cur_bit = fifo_rdata[3];
        d.shreg = {fifo_rdata[2:0], 1'b0};
      end else begin
        d.cur_bit = q.shreg[3];
        d.shreg = {q.shreg[2:0], 1'b0};
      end
      // CMI: a one holds alternating levels, a zero goes low then high.
      if (d.cur_bit) begin
        d.cmi_lvl = ~q.cmi_lvl;
        d.coax = d.cmi_lvl;
      end else begin
        d.coax = 1'b0;
      end
    end else if (mid_bit && !q.cur_bit) begin
      d.coax = 1'b1;
    end
    d.par_clk = (d.bitcnt == 2'h0) || (d.bitcnt == 2'h1);
    // Serial input activity watch for the clock-recovery mode only.
    d.ser_prev = lvl.ser_data;
    if (q.mode != tsp_pkg::TSP_SER_CDR || lvl.ser_data != q.ser_prev) begin
      d.idle_cnt = 16'h0000;
    end else if (q.idle_cnt != 16'(TX_INPUT_UNLOCKED_FLAG_CYCLES)) begin
      d.idle_cnt = q.idle_cnt + 16'h0001;
    end
    // Register writes.
    if (REG_WR) begin
      case (REG_ADDR)
        tsp_pkg::REG_MODE: begin
          if (REG_WDATA[2:0] <= 3'h4) begin
            d.mode = tsp_pkg::tsp_mode_type'(REG_WDATA[2:0]);
          end
          d.tx_en = REG_WDATA[tsp_pkg::MC_TXEN];
        end
        tsp_pkg::REG_SIGCTL: begin
          d.tx_clock_edge_invert = REG_WDATA[tsp_pkg::SC_TX_CLOCK_EDGE_INVERT];
          d.tx_fifo_pointer_reset = REG_WDATA[tsp_pkg::SC_TX_FIFO_POINTER_RESET];
        end
        tsp_pkg::REG_MODE2: begin
          d.cmi = REG_WDATA[tsp_pkg::M2_CMI];
        end
        tsp_pkg::REG_IRQ_MASK: begin
          d.irq_mask = REG_WDATA[tsp_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Status is read-to-clear; a live condition sets it again at once.
    rd_stat = REG_RD && (REG_ADDR == tsp_pkg::REG_STATUS);
    d.stat = (rd_stat ? '0 : q.stat) | cond;
    if (q.tx_fifo_pointer_reset) begin
      d.stat[tsp_pkg::ST_TX_FIFO_PHASE_ERROR] = 1'b0;
    end
    // Interrupt status: new conditions set, written ones clear, set wins.
    d.irq_stat = q.irq_stat | (cond & ~q.prev);
    if (REG_WR && REG_ADDR == tsp_pkg::REG_IRQ_STAT) begin
      d.irq_stat = (q.irq_stat & ~REG_WDATA[tsp_pkg::EV_W-1:0]) |
                   (cond & ~q.prev);
    end
    d.prev = cond;
    d.irq = |(d.irq_stat & d.irq_mask);
    // Read data stands only in the cycle after the strobe.
    d.rdata = REG_RD ? read_value(REG_ADDR, q) : 8'h00;
    // Pin enables follow the configuration being loaded.
    d.par_oe = (d.mode == tsp_pkg::TSP_MASTER_PAR);
    d.coax_oe = d.tx_en && d.cmi;
    d.nrz = d.cmi ? 1'b0 : d.cur_bit;
  end

  // Event conditions in status layout; lock loss is hidden under LOS.
  assign tx_input_unlocked_flag_cond = (q.mode == tsp_pkg::TSP_SER_CDR) &&
                      (q.idle_cnt == 16'(TX_INPUT_UNLOCKED_FLAG_CYCLES));
  assign cond = {lvl.rx_los, lvl.rx_ppm && !lvl.rx_los, 1'b0,
                 tx_input_unlocked_flag_cond, fifo_err};

  // All state registers; the clock enable freezes everything.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.mode <= tsp_pkg::tsp_mode_type'(tsp_pkg::MODE_RST[2:0]);
      q.tx_en <= tsp_pkg::MODE_RST[tsp_pkg::MC_TXEN];
      q.tx_clock_edge_invert <= tsp_pkg::SIGCTL_RST[tsp_pkg::SC_TX_CLOCK_EDGE_INVERT];
      q.tx_fifo_pointer_reset <= tsp_pkg::SIGCTL_RST[tsp_pkg::SC_TX_FIFO_POINTER_RESET];
      q.cmi <= tsp_pkg::MODE2_RST[tsp_pkg::M2_CMI];
      q.bitcnt <= 2'h3;
      q.par_oe <= 1'b1;
      q.coax_oe <= 1'b1;
    end else if (CE) begin
      q <= d;
    end
  end

  // Every output comes straight from a state flop.
  assign REG_RDATA = q.rdata;
  assign PAR_TX_CLOCK_OUT = q.par_clk;
  assign PAR_TX_CLOCK_OE = q.par_oe;
  assign COAX_LINE_OUT = q.coax;
  assign COAX_LINE_OE = q.coax_oe;
  assign LINE_TX_CLOCK_OUT = q.line_clk;
  assign OPTICAL_NRZ_OUT = q.nrz;
  assign IRQ = q.irq;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  AST_RX_SIGNAL_LOST_FLAG_SHOWN: assert property (
    (CE && lvl.rx_los) |=> q.stat[tsp_pkg::ST_RX_SIGNAL_LOST_FLAG])
    else $error("Loss of signal not shown in status.");
  AST_RX_CLOCK_UNLOCKED_FLAG_HIDDEN: assert property (
    (CE && lvl.rx_los && !q.stat[tsp_pkg::ST_RX_CLOCK_UNLOCKED_FLAG]) |=>
      !q.stat[tsp_pkg::ST_RX_CLOCK_UNLOCKED_FLAG])
    else $error("Lock loss reported during loss of signal.");
  AST_TX_INPUT_UNLOCKED_FLAG_MODE: assert property (
    (q.mode != tsp_pkg::TSP_SER_CDR) |-> !tx_input_unlocked_flag_cond)
    else $error("Serial input loss flagged outside recovery mode.");
  AST_TX_FIFO_PHASE_ERROR_SET: assert property (
    (CE && fifo_err && !q.tx_fifo_pointer_reset) |=> q.stat[tsp_pkg::ST_TX_FIFO_PHASE_ERROR])
    else $error("FIFO error not latched in status.");
  AST_TX_FIFO_PHASE_ERROR_CLEAR: assert property (
    (CE && q.tx_fifo_pointer_reset) |=> !q.stat[tsp_pkg::ST_TX_FIFO_PHASE_ERROR] && !fifo_err)
    else $error("FIFO error survived pointer reset.");
  AST_MSB_FIRST: assert property (
    (CE && fifo_rd) |=> (q.cur_bit == $past(fifo_rdata[3])))
    else $error("Nibble not sent most significant bit first.");
  AST_PAR_OE: assert property (
    PAR_TX_CLOCK_OE == (q.mode == tsp_pkg::TSP_MASTER_PAR))
    else $error("Parallel clock output enable wrong for mode.");
  AST_COAX_HIZ: assert property (
    (!q.tx_en || !q.cmi) |-> !COAX_LINE_OE)
    else $error("Coax output driven while disabled.");
  AST_LINE_CLK: assert property (
    (CE && q.qcnt == 8'(QUARTER_DIV - 1)) |=> $changed(LINE_TX_CLOCK_OUT))
    else $error("Line clock failed to toggle.");
  AST_NRZ_QUIET: assert property (
    (q.cmi && CE) |=> !OPTICAL_NRZ_OUT || !q.cmi)
    else $error("Optical output active in coax mode.");
  AST_FOUR_BITS: assert property (
    (CE && fifo_rd) |-> (q.bitcnt == 2'h3) && (q.quarter == 2'h3))
    else $error("Nibble loaded off the four-bit boundary.");

endmodule
